// ==== verilog/tkb_timekeeping_regs.sv ====
`timescale 1ns/1ps
module tkb_timekeeping_regs #(
    parameter int unsigned ONESHOT_LONG_CYC = tkb_pkg::ONESHOT_LONG_CYC,
    parameter int unsigned ONESHOT_SHORT_CYC = tkb_pkg::ONESHOT_SHORT_CYC,
    parameter int unsigned SW_TICK_CYC = tkb_pkg::HUNDREDTH_CYC,
    parameter int unsigned CT_PRESCALE = tkb_pkg::LS_PRESCALE
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [tkb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic lowSpeedOsc,
    input wire logic highSpeedOsc,
    output logic freqOut,
    output logic watchdogRestart,
    output logic buzzerGate,
    output logic oneshotActive,
    output logic envelopeEnable,
    output logic envelopeDecaySel,
    output logic envelopeClear
);
    import tkb_pkg::*;

    localparam int unsigned CW = $clog2(ONESHOT_LONG_CYC);

    // ------------------------------------------------------------
    // oscillator sampling and binary dividers
    // ------------------------------------------------------------
    logic [1:0] oscIn;
    logic [1:0] oscRise;
    logic [OSC_DIV_W:0] divTap [2];

    assign oscIn = {highSpeedOsc, lowSpeedOsc};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_osc
            logic osc_q, osc_d;
            logic [OSC_DIV_W-1:0] cnt_q, cnt_d;
            always_comb begin
                osc_d = oscIn[gi];
                cnt_d = cnt_q;
                if (oscIn[gi] && !osc_q) begin
                    cnt_d = cnt_q + OSC_DIV_W'(1);
                end
            end
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    osc_q <= 1'b0;
                    cnt_q <= '0;
                end else begin
                    osc_q <= osc_d;
                    cnt_q <= cnt_d;
                end
            end
            assign oscRise[gi] = oscIn[gi] && !osc_q;
            // tap 0 is the oscillator itself, tap n is divide by 2**n
            assign divTap[gi] = {cnt_q, osc_q};
        end
    endgenerate

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] foSel_q, foSel_d;
    logic foEn_q, foEn_d;
    logic ctRun_q, ctRun_d;
    logic swRun_q, swRun_d;
    logic osLen_q, osLen_d;
    logic envDecay_q, envDecay_d;
    logic envOn_q, envOn_d;
    logic buzzer_out_enable_q, buzzer_out_enable_d;
    logic wdPulse_q, wdPulse_d;
    logic ctClr_q, ctClr_d;
    logic swClr_q, swClr_d;
    logic envClr_q, envClr_d;
    logic fout_q, fout_d;
    logic gate_q, gate_d;
    tkb_shot_e shot_q, shot_d;
    logic [CW-1:0] shotCnt_q, shotCnt_d;

    logic [7:0] stages;
    logic [7:0] swBcd;
    logic accept;
    logic wrLane;
    logic busy;

    assign accept = (avs_read || avs_write) && !wait_q;
    assign wrLane = accept && avs_write && avs_byteenable[0];
    assign busy = (shot_q == SHOT_BURST);

    tkb_clock_timer #(
        .PRESCALE(CT_PRESCALE)
    ) u_clock_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .oscRise(oscRise[0]),
        .run(ctRun_q),
        .clear(ctClr_q),
        .stages(stages)
    );

    tkb_stopwatch #(
        .TICK_CYC(SW_TICK_CYC)
    ) u_stopwatch (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .run(swRun_q),
        .clear(swClr_q),
        .bcd(swBcd)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        // one wait state per access keeps readdata straight from a flop
        wait_d = !((avs_read || avs_write) && wait_q);
        rdata_d = rdata_q;
        foSel_d = foSel_q;
        foEn_d = foEn_q;
        ctRun_d = ctRun_q;
        swRun_d = swRun_q;
        osLen_d = osLen_q;
        envDecay_d = envDecay_q;
        envOn_d = envOn_q;
        buzzer_out_enable_d = buzzer_out_enable_q;
        wdPulse_d = 1'b0;
        ctClr_d = 1'b0;
        swClr_d = 1'b0;
        envClr_d = 1'b0;
        shot_d = shot_q;
        shotCnt_d = shotCnt_q;

        if (avs_read && wait_q) begin // load in the wait state: data stands with waitrequest low
            rdata_d = 32'h0000_0000;
            if (regHit(avs_address, IDX_CLK_CTRL)) begin
                rdata_d[FO_SEL_HI:FO_SEL_LO] = foSel_q;
                rdata_d[FO_EN] = foEn_q;
                rdata_d[CT_RUN] = ctRun_q;
            end else if (regHit(avs_address, IDX_STAGE)) begin
                rdata_d[7:0] = stages;
            end else if (regHit(avs_address, IDX_SW_CTRL)) begin
                rdata_d[SW_RUN] = swRun_q;
            end else if (regHit(avs_address, IDX_SW_BCD)) begin
                rdata_d[7:0] = swBcd;
            end else if (regHit(avs_address, IDX_BUZ_CTRL)) begin
                rdata_d[OS_TRIG] = busy;
                rdata_d[OS_LEN] = osLen_q;
                rdata_d[ENV_DECAY] = envDecay_q;
                rdata_d[ENV_EN] = envOn_q;
                rdata_d[BZ_EN] = buzzer_out_enable_q;
            end
        end

        if (wrLane && regHit(avs_address, IDX_CLK_CTRL)) begin
            foSel_d = avs_writedata[FO_SEL_HI:FO_SEL_LO];
            foEn_d = avs_writedata[FO_EN];
            ctRun_d = avs_writedata[CT_RUN];
            wdPulse_d = avs_writedata[WD_RESTART];
            ctClr_d = avs_writedata[CT_CLEAR];
        end
        if (wrLane && regHit(avs_address, IDX_SW_CTRL)) begin
            swRun_d = avs_writedata[SW_RUN];
            swClr_d = avs_writedata[SW_CLEAR];
        end

        // burst countdown
        if (busy) begin
            if (shotCnt_q == '0) begin
                shot_d = SHOT_IDLE;
            end else begin
                shotCnt_d = shotCnt_q - CW'(1);
            end
        end

        if (wrLane && regHit(avs_address, IDX_BUZ_CTRL)) begin
            osLen_d = avs_writedata[OS_LEN];
            envDecay_d = avs_writedata[ENV_DECAY];
            envOn_d = avs_writedata[ENV_EN];
            buzzer_out_enable_d = avs_writedata[BZ_EN];
            envClr_d = avs_writedata[ENV_CLEAR];
            // stop beats a trigger written in the same word
            if (avs_writedata[OS_STOP]) begin
                shot_d = SHOT_IDLE;
                shotCnt_d = '0;
            end else if (avs_writedata[OS_TRIG]) begin
                shot_d = SHOT_BURST;
                // the length bit written in this same word applies
                shotCnt_d = avs_writedata[OS_LEN] ? CW'(ONESHOT_LONG_CYC - 1)
                                                  : CW'(ONESHOT_SHORT_CYC - 1);
            end
        end

        if (shot_d == SHOT_BURST) begin
            envOn_d = 1'b0;
        end

        // select bit 2 low picks the slow oscillator, bits 1:0 pick the tap
        fout_d = 1'b0;
        if (foEn_q) begin
            fout_d = divTap[foSel_q[2]][foSel_q[1:0]];
        end
        gate_d = buzzer_out_enable_q || busy;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            foSel_q <= 3'h0;
            foEn_q <= 1'b0;
            ctRun_q <= 1'b0;
            swRun_q <= 1'b0;
            osLen_q <= 1'b0;
            envDecay_q <= 1'b0;
            envOn_q <= 1'b0;
            buzzer_out_enable_q <= 1'b0;
            wdPulse_q <= 1'b0;
            ctClr_q <= 1'b0;
            swClr_q <= 1'b0;
            envClr_q <= 1'b0;
            fout_q <= 1'b0;
            gate_q <= 1'b0;
            shot_q <= SHOT_IDLE;
            shotCnt_q <= '0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            foSel_q <= foSel_d;
            foEn_q <= foEn_d;
            ctRun_q <= ctRun_d;
            swRun_q <= swRun_d;
            osLen_q <= osLen_d;
            envDecay_q <= envDecay_d;
            envOn_q <= envOn_d;
            buzzer_out_enable_q <= buzzer_out_enable_d;
            wdPulse_q <= wdPulse_d;
            ctClr_q <= ctClr_d;
            swClr_q <= swClr_d;
            envClr_q <= envClr_d;
            fout_q <= fout_d;
            gate_q <= gate_d;
            shot_q <= shot_d;
            shotCnt_q <= shotCnt_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign freqOut = fout_q;
    assign watchdogRestart = wdPulse_q;
    assign buzzerGate = gate_q;
    assign oneshotActive = shot_q[1];
    assign envelopeEnable = envOn_q;
    assign envelopeDecaySel = envDecay_q;
    assign envelopeClear = envClr_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fout_off;
        @(posedge core_clk) disable iff (sys_rst)
        !foEn_q |=> !freqOut;
    endproperty
    a_fout_off: assert property (p_fout_off) else $error("clock output active while off");

    property p_stage_read;
        @(posedge core_clk) disable iff (sys_rst)
        (avs_read && wait_q && regHit(avs_address, IDX_STAGE))
            |=> (avs_readdata == {24'h000000, $past(stages)});
    endproperty
    a_stage_read: assert property (p_stage_read) else $error("stage readout mismatch");

    property p_stop;
        @(posedge core_clk) disable iff (sys_rst)
        (wrLane && regHit(avs_address, IDX_BUZ_CTRL) && avs_writedata[OS_STOP])
            |=> !oneshotActive;
    endproperty
    a_stop: assert property (p_stop) else $error("burst survived a stop");

    property p_trig;
        @(posedge core_clk) disable iff (sys_rst)
        (wrLane && regHit(avs_address, IDX_BUZ_CTRL) && avs_writedata[OS_TRIG]
            && !avs_writedata[OS_STOP]) |=> oneshotActive ##1 oneshotActive;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not start a burst");

    property p_len;
        @(posedge core_clk) disable iff (sys_rst)
        (wrLane && regHit(avs_address, IDX_BUZ_CTRL) && avs_writedata[OS_TRIG]
            && !avs_writedata[OS_STOP])
            |=> (shotCnt_q == ($past(avs_writedata[OS_LEN]) ? CW'(ONESHOT_LONG_CYC - 1)
                                                              : CW'(ONESHOT_SHORT_CYC - 1)));
    endproperty
    a_len: assert property (p_len) else $error("burst length wrong");

    property p_env_off;
        @(posedge core_clk) disable iff (sys_rst)
        oneshotActive |-> !envelopeEnable;
    endproperty
    a_env_off: assert property (p_env_off) else $error("envelope on during burst");

    property p_wd_pulse;
        @(posedge core_clk) disable iff (sys_rst)
        (wrLane && regHit(avs_address, IDX_CLK_CTRL) && avs_writedata[WD_RESTART])
            |=> watchdogRestart ##1 !watchdogRestart;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog restart not one pulse");

    property p_wait;
        @(posedge core_clk) disable iff (sys_rst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("access not answered in one wait state");

    c_trig: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(oneshotActive));
    c_stop: cover property (@(posedge core_clk) disable iff (sys_rst)
        oneshotActive ##1 (wrLane && avs_writedata[OS_STOP]));
    c_end: cover property (@(posedge core_clk) disable iff (sys_rst) $fell(oneshotActive));

endmodule : tkb_timekeeping_regs

// ==== verilog/tkb_pkg.sv ====
package tkb_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned ONESHOT_LONG_US = 125000;
    localparam int unsigned ONESHOT_SHORT_US = 31250;
    localparam int unsigned HUNDREDTH_US = 10000;
    localparam int unsigned ONESHOT_LONG_CYC = ONESHOT_LONG_US * CLK_MHZ;
    localparam int unsigned ONESHOT_SHORT_CYC = ONESHOT_SHORT_US * CLK_MHZ;
    localparam int unsigned HUNDREDTH_CYC = HUNDREDTH_US * CLK_MHZ;
    // low-speed oscillator edges per 256 Hz stage tick
    localparam int unsigned LS_PRESCALE = 128;
    localparam int unsigned OSC_DIV_W = 3;

    // ------------------------------------------------------------
    // register map: printed offsets are indices, byte address = 4 * index
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 18;
    localparam logic [15:0] IDX_CLK_CTRL = 16'hff40;
    localparam logic [15:0] IDX_STAGE = 16'hff41;
    localparam logic [15:0] IDX_SW_CTRL = 16'hff42;
    localparam logic [15:0] IDX_SW_BCD = 16'hff43;
    localparam logic [15:0] IDX_BUZ_CTRL = 16'hff44;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // clock_output_and_timer_ctrl fields
    localparam int unsigned FO_SEL_HI = 6;
    localparam int unsigned FO_SEL_LO = 4;
    localparam int unsigned FO_EN = 3;
    localparam int unsigned WD_RESTART = 2;
    localparam int unsigned CT_CLEAR = 1;
    localparam int unsigned CT_RUN = 0;
    // stopwatch_ctrl fields
    localparam int unsigned SW_CLEAR = 1;
    localparam int unsigned SW_RUN = 0;
    // buzzer_oneshot_envelope_ctrl fields
    localparam int unsigned OS_STOP = 6;
    localparam int unsigned OS_TRIG = 5;
    localparam int unsigned OS_LEN = 4;
    localparam int unsigned ENV_DECAY = 3;
    localparam int unsigned ENV_CLEAR = 2;
    localparam int unsigned ENV_EN = 1;
    localparam int unsigned BZ_EN = 0;

    typedef enum logic [1:0] {
        SHOT_IDLE = 2'b01,
        SHOT_BURST = 2'b10
    } tkb_shot_e;

    function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
        regHit = (addr == {idx, 2'b00});
    endfunction : regHit

endpackage : tkb_pkg

// ==== verilog/tkb_clock_timer.sv ====
`timescale 1ns/1ps
module tkb_clock_timer #(
    parameter int unsigned PRESCALE = tkb_pkg::LS_PRESCALE
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic oscRise,
    input wire logic run,
    input wire logic clear,
    output logic [7:0] stages
);
    import tkb_pkg::*;

    localparam int unsigned PW = $clog2(PRESCALE);

    logic [PW-1:0] pre_q, pre_d;
    logic [7:0] stage_q, stage_d;

    // ------------------------------------------------------------
    // prescaler and divider stages
    // ------------------------------------------------------------
    always_comb begin
        pre_d = pre_q;
        stage_d = stage_q;
        if (clear) begin
            pre_d = '0;
            stage_d = RST_BYTE;
        end else if (run && oscRise) begin
            if (pre_q == PW'(PRESCALE - 1)) begin
                pre_d = '0;
                stage_d = stage_q + 8'h01;
            end else begin
                pre_d = pre_q + PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pre_q <= '0;
            stage_q <= RST_BYTE;
        end else begin
            pre_q <= pre_d;
            stage_q <= stage_d;
        end
    end

    assign stages = stage_q;

    property p_ct_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (!run && !clear) |=> $stable(stage_q) && $stable(pre_q);
    endproperty
    a_ct_hold: assert property (p_ct_hold) else $error("clock timer moved while stopped");

endmodule : tkb_clock_timer

// ==== verilog/tkb_stopwatch.sv ====
`timescale 1ns/1ps
module tkb_stopwatch #(
    parameter int unsigned TICK_CYC = tkb_pkg::HUNDREDTH_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic clear,
    output logic [7:0] bcd
);
    import tkb_pkg::*;

    localparam int unsigned TW = $clog2(TICK_CYC);

    logic [TW-1:0] tick_q, tick_d;
    logic [3:0] tenth_q, tenth_d;
    logic [3:0] hund_q, hund_d;

    // ------------------------------------------------------------
    // 1/100 s tick and two decade digits
    // ------------------------------------------------------------
    always_comb begin
        tick_d = tick_q;
        tenth_d = tenth_q;
        hund_d = hund_q;
        if (clear) begin
            tick_d = '0;
            tenth_d = 4'h0;
            hund_d = 4'h0;
        end else if (run) begin
            if (tick_q == TW'(TICK_CYC - 1)) begin
                tick_d = '0;
                if (hund_q == 4'h9) begin
                    hund_d = 4'h0;
                    tenth_d = (tenth_q == 4'h9) ? 4'h0 : tenth_q + 4'h1;
                end else begin
                    hund_d = hund_q + 4'h1;
                end
            end else begin
                tick_d = tick_q + TW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tick_q <= '0;
            tenth_q <= 4'h0;
            hund_q <= 4'h0;
        end else begin
            tick_q <= tick_d;
            tenth_q <= tenth_d;
            hund_q <= hund_d;
        end
    end

    assign bcd = {tenth_q, hund_q};

    property p_sw_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (!run && !clear) |=> $stable(bcd);
    endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("stopwatch moved while stopped");

    property p_sw_bcd;
        @(posedge core_clk) disable iff (sys_rst)
        (tenth_q <= 4'h9) && (hund_q <= 4'h9);
    endproperty
    a_sw_bcd: assert property (p_sw_bcd) else $error("stopwatch digit above nine");

    c_sw_wrap: cover property (@(posedge core_clk) disable iff (sys_rst)
        (bcd == 8'h99) ##1 (bcd == 8'h00));

endmodule : tkb_stopwatch

// ==== tb/tkb_timekeeping_regs_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tkb_timekeeping_regs_tb;
    import tkb_pkg::*;
    // ------------------------------------------------------------
    // shortened counts
    // ------------------------------------------------------------
    localparam int LONG = 40;
    localparam int SHORT = 10;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic lowSpeedOsc = 1'b0;
    logic highSpeedOsc = 1'b0;
    logic freqOut, watchdogRestart, buzzerGate, oneshotActive;
    logic envelopeEnable, envelopeDecaySel, envelopeClear;
    logic [1:0] oscCnt = 2'b00;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    logic [31:0] e, m, d, d2;
    int errors = 0, checked = 0, cyc = 0, runLen = 0, lastLen = 0;
    int foRise = 0, wdCnt = 0, ecCnt = 0, r0, x;
    logic foPrev = 1'b0;
    tkb_timekeeping_regs #(.ONESHOT_LONG_CYC(LONG), .ONESHOT_SHORT_CYC(SHORT),
        .SW_TICK_CYC(4), .CT_PRESCALE(2)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lowSpeedOsc(lowSpeedOsc),
        .highSpeedOsc(highSpeedOsc), .freqOut(freqOut), .watchdogRestart(watchdogRestart),
        .buzzerGate(buzzerGate), .oneshotActive(oneshotActive),
        .envelopeEnable(envelopeEnable), .envelopeDecaySel(envelopeDecaySel),
        .envelopeClear(envelopeClear));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // oscillators: slow period 4 cycles, fast period 2 cycles
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        oscCnt <= oscCnt + 2'd1;
        lowSpeedOsc <= oscCnt[1];
        highSpeedOsc <= oscCnt[0];
    end
    // ------------------------------------------------------------
    // output watcher: read notes, pulses, burst length, edges
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            m = mskQ.pop_front();
            if (m != 32'h0) `CHK(avs_readdata & m, e)
        end
        if (watchdogRestart === 1'b1) wdCnt++;
        if (envelopeClear === 1'b1) ecCnt++;
        if (oneshotActive === 1'b1) runLen++;
        else if (runLen != 0) begin
            lastLen = runLen;
            runLen = 0;
        end
        if (freqOut === 1'b1 && foPrev === 1'b0) foRise++;
        foPrev = freqOut;
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // avalon master: hold until waitrequest sampled low
    // ------------------------------------------------------------
    task automatic busAcc(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rd);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        // no local limit: the cycle ceiling ends a hung access
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : busAcc
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] r;
        busAcc(idx, 1'b1, wd, 4'h1, r);
    endtask : wr
    task automatic rdChk(input logic [15:0] idx, input logic [31:0] ex);
        logic [31:0] r;
        expQ.push_back(ex);
        mskQ.push_back(32'hffffffff);
        busAcc(idx, 1'b0, 32'h0, 4'h0, r);
    endtask : rdChk
    task automatic rdGet(input logic [15:0] idx, output logic [31:0] r);
        expQ.push_back(32'h0);
        mskQ.push_back(32'h0);
        busAcc(idx, 1'b0, 32'h0, 4'h0, r);
    endtask : rdGet
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (oneshotActive !== 1'b0 && n < 200);
        repeat (2) @(posedge core_clk);
    endtask : waitIdle
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h22e13709));
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) rdChk(16'(IDX_CLK_CTRL + i), 32'h0);
        rdChk(16'hff45, 32'h0);
        wr(16'hff45, $urandom);
        rdChk(16'hff45, 32'h0);
        $display("test reset_map done");
        for (int s = 0; s < 8; s++) begin
            wr(IDX_CLK_CTRL, (s << 4) | 32'h8);
            rdChk(IDX_CLK_CTRL, (s << 4) | 32'h8);
            repeat (16) @(posedge core_clk);
            r0 = foRise;
            repeat (128) @(posedge core_clk);
            x = ((s < 4) ? 32 : 64) >> (s % 4);
            `CHK((foRise - r0 >= x - 1) && (foRise - r0 <= x + 1), 1'b1)
        end
        wr(IDX_CLK_CTRL, 32'h70);
        repeat (4) @(posedge core_clk);
        `CHK(freqOut, 1'b0)
        $display("test freq_out done");
        rdChk(IDX_STAGE, 32'h0);
        wr(IDX_CLK_CTRL, 32'h1);
        // lane 0 off: write ignored, timer keeps running
        busAcc(IDX_CLK_CTRL, 1'b1, 32'h0, 4'he, d);
        rdChk(IDX_CLK_CTRL, 32'h1);
        repeat (40) @(posedge core_clk);
        wr(IDX_CLK_CTRL, 32'h0);
        rdGet(IDX_STAGE, d);
        `CHK(d > 0 && d < 32, 1'b1)
        repeat (20) @(posedge core_clk);
        rdGet(IDX_STAGE, d2);
        `CHK(d2, d)
        r0 = wdCnt;
        wr(IDX_CLK_CTRL, 32'h7);
        rdChk(IDX_CLK_CTRL, 32'h1);
        `CHK(wdCnt - r0, 1)
        rdChk(IDX_STAGE, 32'h0);
        $display("test clock_timer done");
        wr(IDX_SW_CTRL, 32'h1);
        repeat (188) @(posedge core_clk);
        wr(IDX_SW_CTRL, 32'h0);
        rdGet(IDX_SW_BCD, d);
        x = d[7:4] * 10 + d[3:0];
        `CHK(d[7:4] < 10 && d[3:0] < 10 && x >= 44 && x <= 51, 1'b1)
        repeat (20) @(posedge core_clk);
        rdGet(IDX_SW_BCD, d2);
        `CHK(d2, d)
        wr(IDX_SW_CTRL, ($urandom & 32'hfffffffc) | 32'h2);
        rdChk(IDX_SW_CTRL, 32'h0);
        rdChk(IDX_SW_BCD, 32'h0);
        $display("test stopwatch done");
        r0 = ecCnt;
        wr(IDX_BUZ_CTRL, 32'h0f);
        rdChk(IDX_BUZ_CTRL, 32'h0b);
        `CHK({buzzerGate, envelopeDecaySel, envelopeEnable}, 3'b111)
        `CHK(ecCnt - r0, 1)
        wr(IDX_BUZ_CTRL, 32'h02);
        wr(IDX_BUZ_CTRL, 32'h22);
        repeat (3) @(posedge core_clk);
        `CHK({oneshotActive, buzzerGate, envelopeEnable}, 3'b110)
        rdChk(IDX_BUZ_CTRL, 32'h20);
        waitIdle();
        `CHK(lastLen, SHORT)
        rdChk(IDX_BUZ_CTRL, 32'h00);
        wr(IDX_BUZ_CTRL, 32'h30);
        rdChk(IDX_BUZ_CTRL, 32'h30);
        waitIdle();
        `CHK(lastLen, LONG)
        wr(IDX_BUZ_CTRL, 32'h30);
        repeat (5) @(posedge core_clk);
        wr(IDX_BUZ_CTRL, 32'h50);
        repeat (2) @(posedge core_clk);
        `CHK(oneshotActive, 1'b0)
        rdChk(IDX_BUZ_CTRL, 32'h10);
        waitIdle();
        `CHK(lastLen < 20, 1'b1)
        $display("test oneshot done");
        wr(IDX_CLK_CTRL, 32'h19);
        wr(IDX_SW_CTRL, 32'h1);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdChk(IDX_CLK_CTRL, 32'h0);
        rdChk(IDX_SW_CTRL, 32'h0);
        $display("test second_reset done");
        final_report();
    end
endmodule : tkb_timekeeping_regs_tb
